//--- rtl/program_counter_loader.sv
// Program counter with low-byte register and upper address latch
`timescale 1ns/1ps
`include "pc_loader_map.svh"
module program_counter_loader
   import pc_loader_pkg::*;
(
   input  wire logic                      CLK_I,         // Core clock
   input  wire logic                      RST_I,         // Sync reset, high
   input  wire logic                      CE_I,          // Clock enable
   input  wire logic                      ADVANCE_I,     // Step to next instr
   input  wire logic                      LOW_WR_I,      // Write low byte
   input  wire logic [`PC_LOW_WIDTH-1:0]  LOW_DATA_I,    // Low byte value
   input  wire logic                      LATCH_WR_I,    // Write latch
   input  wire logic [`LATCH_WIDTH-1:0]   LATCH_DATA_I,  // Latch value
   input  wire logic                      JUMP_I,        // Jump or call
   input  wire logic [`JUMP_FIELD_W-1:0]  JUMP_ADDR_I,   // Instruction field
   input  wire logic                      RESTORE_I,     // Return from stack
   input  wire logic [`PC_WIDTH-1:0]      STACK_PC_I,    // Popped address
   output logic      [`PC_WIDTH-1:0]      PC_O,          // Program counter
   output logic      [`PC_LOW_WIDTH-1:0]  LOW_BYTE_O,    // Low byte readback
   output logic      [`LATCH_WIDTH-1:0]   LATCH_O        // Latch readback
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   pc_t                       pc_q, pc_d;
   logic [`LATCH_WIDTH-1:0]   latch_q, latch_d;
   pc_load_if                 lif ();

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // One decode shared by the next-value logic and the hold check
   function automatic logic pc_moves(input logic low_wr,
                                     input logic jump,
                                     input logic restore,
                                     input logic advance);
      return low_wr || jump || restore || advance;
   endfunction

   // ----------------------------------------------------------------
   // Load selection
   // ----------------------------------------------------------------
   // Low-byte write outranks a jump; restore outranks plain stepping
   always_comb begin
      if (LOW_WR_I) begin
         lif.sel = LOAD_LOW_WRITE;
      end else if (JUMP_I) begin
         lif.sel = LOAD_JUMP;
      end else if (RESTORE_I) begin
         lif.sel = LOAD_RESTORE;
      end else begin
         lif.sel = LOAD_INC;
      end
   end

   assign lif.cur_pc    = pc_q;
   assign lif.latch     = latch_q;
   assign lif.low_data  = LOW_DATA_I;
   assign lif.jump_addr = JUMP_ADDR_I;
   assign lif.stack_pc  = STACK_PC_I;

   pc_next_select u_sel (
      .lif (lif.selector)
   );

   // ----------------------------------------------------------------
   // Next values
   // ----------------------------------------------------------------
   always_comb begin
      pc_d    = pc_q;
      latch_d = latch_q;
      // A latch write alone leaves the counter where it is
      if (pc_moves(LOW_WR_I, JUMP_I, RESTORE_I, ADVANCE_I)) begin
         pc_d = lif.next_pc;
      end
      // Only a direct write changes the latch, never a push or pop
      if (LATCH_WR_I) begin
         latch_d = LATCH_DATA_I;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         pc_q    <= `PC_RESET_VALUE;
         latch_q <= `LATCH_RESET_VAL;
      end else if (CE_I) begin
         pc_q    <= pc_d;
         latch_q <= latch_d;
      end
   end

   assign PC_O       = pc_q;
   assign LOW_BYTE_O = pc_q[`PC_LOW_WIDTH-1:0];
   assign LATCH_O    = latch_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_low_write;
      CE_I && !RST_I && LOW_WR_I;
   endsequence

   // First step of a computed jump: the page goes into the latch
   sequence s_latch_load;
      CE_I && !RST_I && LATCH_WR_I;
   endsequence

   property p_reset_clear;
      @(posedge CLK_I) RST_I |=> (PC_O == 13'h0000);
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("Counter not cleared by reset");

   // Latch clears together with the counter
   property p_reset_latch;
      @(posedge CLK_I) RST_I |=> (LATCH_O == 8'h00);
   endproperty
   a_reset_latch: assert property (p_reset_latch)
      else $error("Latch not cleared by reset");

   property p_low_write;
      @(posedge CLK_I) disable iff (RST_I)
      s_low_write |=> PC_O == {$past(latch_q[4:0]), $past(LOW_DATA_I)};
   endproperty
   a_low_write: assert property (p_low_write)
      else $error("Low byte write did not load all bits");

   property p_jump;
      @(posedge CLK_I) disable iff (RST_I)
      (CE_I && !RST_I && JUMP_I && !LOW_WR_I) |=>
         PC_O == {$past(latch_q[4:3]), $past(JUMP_ADDR_I)};
   endproperty
   a_jump: assert property (p_jump)
      else $error("Jump target wrong");

   property p_latch_stable;
      @(posedge CLK_I) disable iff (RST_I)
      (CE_I && !RST_I && !LATCH_WR_I) |=> $stable(LATCH_O);
   endproperty
   a_latch_stable: assert property (p_latch_stable)
      else $error("Latch changed without a write");

   // A latch write loads its data into the latch on the next cycle
   property p_latch_write;
      @(posedge CLK_I) disable iff (RST_I)
      (CE_I && !RST_I && LATCH_WR_I) |=>
         LATCH_O == $past(LATCH_DATA_I);
   endproperty
   a_latch_write: assert property (p_latch_write)
      else $error("Latch write not taken");

   property p_upper_hidden;
      @(posedge CLK_I) disable iff (RST_I)
      (CE_I && !RST_I && !LOW_WR_I && !JUMP_I && !RESTORE_I && ADVANCE_I) |=>
         PC_O == $past(PC_O) + 13'h0001;
   endproperty
   a_upper_hidden: assert property (p_upper_hidden)
      else $error("Counter did not step");

   // Readback follows every plain step of the counter
   property p_advance_low;
      @(posedge CLK_I) disable iff (RST_I)
      (CE_I && !RST_I && ADVANCE_I && !LOW_WR_I && !JUMP_I && !RESTORE_I)
         |=> LOW_BYTE_O == $past(LOW_BYTE_O) + 8'h01;
   endproperty
   a_advance_low: assert property (p_advance_low)
      else $error("Low byte readback did not step");

   // With no request taken the counter must hold
   property p_idle_hold;
      @(posedge CLK_I) disable iff (RST_I)
      (CE_I && !RST_I && !pc_moves(LOW_WR_I, JUMP_I, RESTORE_I, ADVANCE_I))
         |=> $stable(PC_O);
   endproperty
   a_idle_hold: assert property (p_idle_hold)
      else $error("Counter moved with no request");

   property p_freeze;
      @(posedge CLK_I) disable iff (RST_I)
      (!CE_I && !RST_I) |=> $stable(PC_O) && $stable(LATCH_O);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("State moved with clock enable low");

   property p_readback;
      @(posedge CLK_I) disable iff (RST_I)
      s_low_write |=> LOW_BYTE_O == $past(LOW_DATA_I);
   endproperty
   a_readback: assert property (p_readback)
      else $error("Low byte readback wrong");

   property p_restore;
      @(posedge CLK_I) disable iff (RST_I)
      (CE_I && !RST_I && RESTORE_I && !LOW_WR_I && !JUMP_I) |=>
         PC_O == $past(STACK_PC_I);
   endproperty
   a_restore: assert property (p_restore)
      else $error("Restore address wrong");

   // Stack traffic leaves the latch as it was
   property p_restore_latch;
      @(posedge CLK_I) disable iff (RST_I)
      (CE_I && !RST_I && RESTORE_I && !LATCH_WR_I) |=>
         LATCH_O == $past(LATCH_O);
   endproperty
   a_restore_latch: assert property (p_restore_latch)
      else $error("Latch moved on a restore");

   // Latch, then low byte: upper bits follow the earlier latch write
   property p_computed_jump;
      @(posedge CLK_I) disable iff (RST_I)
      s_latch_load ##1 s_low_write |=>
         PC_O[12:8] == $past(LATCH_DATA_I[4:0], 2);
   endproperty
   a_computed_jump: assert property (p_computed_jump)
      else $error("Computed jump left the latch page");
endmodule

//--- include/pc_loader_map.svh
// Constants for the program counter loader
`ifndef PC_LOADER_MAP_SVH
`define PC_LOADER_MAP_SVH
`define PC_WIDTH        13
`define PC_LOW_WIDTH    8
`define PC_HIGH_WIDTH   5
`define LATCH_WIDTH     8
`define JUMP_FIELD_W    11
`define PC_RESET_VALUE  13'h0000
`define LATCH_RESET_VAL 8'h00
`define LATCH_JUMP_MSB  4
`define LATCH_JUMP_LSB  3
`endif

//--- include/pc_loader_pkg.sv
// Types for the program counter loader
`include "pc_loader_map.svh"
package pc_loader_pkg;
   typedef enum logic [1:0] {
      LOAD_INC,
      LOAD_LOW_WRITE,
      LOAD_JUMP,
      LOAD_RESTORE
   } load_sel_t;
   typedef logic [`PC_WIDTH-1:0] pc_t;
endpackage

//--- include/pc_load_if.sv
// Interface joining the loader and its next-address selector
`timescale 1ns/1ps
`include "pc_loader_map.svh"
interface pc_load_if;
   import pc_loader_pkg::*;
   pc_t                        cur_pc;
   logic [`LATCH_WIDTH-1:0]    latch;
   logic [`PC_LOW_WIDTH-1:0]   low_data;
   logic [`JUMP_FIELD_W-1:0]   jump_addr;
   pc_t                        stack_pc;
   load_sel_t                  sel;
   pc_t                        next_pc;
   modport loader (output cur_pc, latch, low_data, jump_addr, stack_pc,
                   sel, input next_pc);
   modport selector (input cur_pc, latch, low_data, jump_addr, stack_pc,
                     sel, output next_pc);
endinterface

//--- rtl/pc_next_select.sv
// Next program counter selection
`timescale 1ns/1ps
`include "pc_loader_map.svh"
module pc_next_select
   import pc_loader_pkg::*;
(
   pc_load_if.selector lif   // Load request and result
);
   always_comb begin
      case (lif.sel)
         LOAD_LOW_WRITE: begin
            // Whole counter changes at once from latch and written byte
            lif.next_pc = {lif.latch[`PC_HIGH_WIDTH-1:0],
                           lif.low_data};
         end
         LOAD_JUMP: begin
            lif.next_pc = {lif.latch[`LATCH_JUMP_MSB:`LATCH_JUMP_LSB],
                           lif.jump_addr};
         end
         LOAD_RESTORE: begin
            lif.next_pc = lif.stack_pc;
         end
         default: begin
            lif.next_pc = pc_t'(lif.cur_pc + pc_t'(1));
         end
      endcase
   end
endmodule

//--- verification/table_jump_model.sv
// Execution-side model that issues computed table jumps
`timescale 1ns/1ps
module table_jump_model
   import pc_loader_pkg::*;
(
   input  wire logic clk_i,      // Core clock
   input  wire logic rst_i,      // Sync reset, high
   input  wire logic req_i,      // Start a table jump
   input  wire pc_t  target_i,   // Table entry address
   output logic      latch_wr_o, // Latch write
   output logic [7:0] latch_o,   // Latch value
   output logic      low_wr_o,   // Low byte write
   output logic [7:0] low_o      // Low byte value
);
   logic [7:0] hi_q;
   logic [7:0] lo_q;
   // Latch from the full sum, so a byte wrap bumps it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         latch_wr_o <= 1'b0;
         low_wr_o   <= 1'b0;
      end else begin
         latch_wr_o <= req_i;
         low_wr_o   <= latch_wr_o;
      end
      if (req_i) begin
         hi_q <= {3'h0, target_i[12:8]};
         lo_q <= target_i[7:0];
      end
   end
   // Stale data inverted so no leftover value can pass
   assign latch_o = latch_wr_o ? hi_q : ~hi_q;
   assign low_o   = low_wr_o ? lo_q : ~lo_q;
endmodule

//--- verification/test_program_counter_loader.sv
// Self-checking bench for the program counter loader
`timescale 1ns/1ps
module test_program_counter_loader;
   import pc_loader_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, adv = 1'b0;
   logic        jmp = 1'b0, rest = 1'b0, req = 1'b0;
   logic [10:0] jaddr = 11'h000;
   pc_t         stk = 13'h0000, tgt = 13'h0000, pc;
   logic        lwr, hwr;
   logic [7:0]  lo_d, hi_d, lowb, lat;
   int          n_errors = 0, n_checks = 0, cycles = 0;
   always #20 clk = ~clk;
   table_jump_model u_exec (.clk_i(clk), .rst_i(rst), .req_i(req),
      .target_i(tgt), .latch_wr_o(hwr), .latch_o(hi_d), .low_wr_o(lwr),
      .low_o(lo_d));
   program_counter_loader u_dut (.CLK_I(clk), .RST_I(rst), .CE_I(ce),
      .ADVANCE_I(adv), .LOW_WR_I(lwr), .LOW_DATA_I(lo_d),
      .LATCH_WR_I(hwr), .LATCH_DATA_I(hi_d), .JUMP_I(jmp),
      .JUMP_ADDR_I(jaddr), .RESTORE_I(rest), .STACK_PC_I(stk),
      .PC_O(pc), .LOW_BYTE_O(lowb), .LATCH_O(lat));
   task automatic chk(string nm, logic [12:0] e, logic [12:0] g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic summarize();
      if (n_errors == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic table_jump(pc_t t);
      @(posedge clk);
      tgt <= t;
      req <= 1'b1;
      @(posedge clk);
      req <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic t_table();
      table_jump(13'h0AF0 + 13'h0020);
      chk("pc", 13'h0B10, pc);
      chk("latch", 13'h000B, {5'h0, lat});
      chk("low", 13'h0010, {5'h0, lowb});
   endtask
   task automatic t_jump();
      table_jump(13'h1800);
      // Restore clears the upper bits so they differ from latch bits 4-3
      @(posedge clk);
      rest <= 1'b1;
      @(posedge clk);
      rest  <= 1'b0;
      jmp   <= 1'b1;
      adv   <= 1'b1;
      jaddr <= 11'h5A5;
      @(posedge clk);
      jmp <= 1'b0;
      adv <= 1'b0;
      #1;
      chk("pc", 13'h1DA5, pc);
      chk("latch", 13'h0018, {5'h0, lat});
   endtask
   task automatic t_restore();
      @(posedge clk);
      rest <= 1'b1;
      adv  <= 1'b1;
      stk  <= 13'h0123;
      @(posedge clk);
      rest <= 1'b0;
      adv  <= 1'b0;
      #1;
      chk("pc", 13'h0123, pc);
      chk("latch", 13'h0018, {5'h0, lat});
   endtask
   task automatic t_advance();
      @(posedge clk);
      adv <= 1'b1;
      @(posedge clk);
      ce <= 1'b0;
      @(posedge clk);
      adv <= 1'b0;
      ce  <= 1'b1;
      #1;
      chk("pc", 13'h0124, pc);
   endtask
   task automatic t_reset();
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      #1;
      chk("pc", 13'h0000, pc);
      chk("latch", 13'h0000, {5'h0, lat});
   endtask
   // Generous ceiling: the whole sequence needs some twenty cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 500) begin
         n_errors++;
         summarize();
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk("pc", 13'h0000, pc);
      t_table();
      t_jump();
      t_restore();
      t_advance();
      t_reset();
      summarize();
   end
endmodule
